//--- rtl/tpa_access_control.sv
// Password access control with an AXI4-Lite configuration port.
`default_nettype none
// Operation
// R1: Hold 32-bit password and 16-bit acknowledge.
// R2: Threshold resets to FFh, protection off.
// R3: Unprotected tag writes password freely.
// R4: Guard threshold page and all above.
// R5: Both values stored low byte first.
// R6: Reads return zero for hidden bytes.
// R7: Unguarded config pages take both write kinds.
// R8: Guarded config pages need prior verification.
// R9: Config lock never blocks password writes.
// R10: Host sets threshold to password page.
// R11: Limit zero disables counting and locking.
// R12: Failure past limit locks permanently.
// R13: After lock every verification fails.
// R14: Success before limit clears the counter.
// R15: Scope bit picks write or read-write.
// R16: Config pages guarded at threshold below.
// R17: Match replies acknowledge, authenticated till deactivation; a later failed verification also ends the session here.
module tpa_access_control #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Command decoder side.
    input wire tpa_pkg::tpa_req_t req,
    output tpa_pkg::tpa_rsp_t rsp,
    // AXI4-Lite write channels.
    input wire logic [tpa_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [tpa_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam logic [7:0] CFG_PAGE = LARGE_VARIANT ? tpa_pkg::LARGE_CFG_PAGE : tpa_pkg::SMALL_CFG_PAGE;
    localparam logic [7:0] PWD_PAGE = LARGE_VARIANT ? tpa_pkg::LARGE_PWD_PAGE : tpa_pkg::SMALL_PWD_PAGE;
    localparam logic [7:0] ACK_PAGE = LARGE_VARIANT ? tpa_pkg::LARGE_ACK_PAGE : tpa_pkg::SMALL_ACK_PAGE;
    localparam logic [7:0] LAST_PAGE = ACK_PAGE;

    // Configuration and secrets.
    logic [7:0] fpp;
    logic [2:0] limit;
    logic scope;
    logic cfg_lock;
    logic [31:0] password;
    logic [15:0] ack_value;
    logic auth;
    // Guard state from the attempt counter.
    logic pass;
    logic locked;
    logic [2:0] fail_count;
    // Request decode.
    logic in_range;
    logic guarded;
    logic cfg_guarded;
    logic protection_scope_bit_active;
    logic open_access;
    logic write_ok;
    logic read_ok;
    logic is_write;
    logic is_verify;
    logic match;
    logic [31:0] masked;
    // Bus holding state.
    logic aw_held;
    logic w_held;
    logic wr_fire;
    logic [tpa_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // R4 R16 guarding threshold decode
    assign in_range = req.page <= LAST_PAGE;
    assign guarded = tpa_pkg::tpa_guarded(req.page, fpp, LAST_PAGE);
    // Any threshold inside memory reaches at least the top configuration page, so that page is always guarded then.
    assign cfg_guarded = tpa_pkg::tpa_guarded(LAST_PAGE, fpp, LAST_PAGE);
    assign protection_scope_bit_active = fpp <= LAST_PAGE;
    // A lock shuts the guarded area even for a session that verified earlier.
    assign open_access = auth && !locked;
    // R3 R7 R8 write permission
    assign write_ok = in_range && (!guarded || open_access);
    // R15 scope selects read guarding
    assign read_ok = in_range && (!guarded || !scope || open_access);
    assign is_write = req.valid && (req.cmd == tpa_pkg::TPA_CMD_WRITE || req.cmd == tpa_pkg::TPA_CMD_COMPAT_WRITE);
    assign is_verify = req.valid && req.cmd == tpa_pkg::TPA_CMD_VERIFY;
    // R5 low byte first in both directions
    assign match = req.data == password;

    // R6 hide secret bytes on reads
    always_comb begin
        masked = req.data;
        if (req.page == PWD_PAGE) begin
            masked = 32'h0000_0000;
        end else if (req.page == ACK_PAGE) begin
            masked[15:0] = 16'h0000;
        end
    end

    // The attempt counter sees every verification; a lock it sets shows from the next verification's reply on.
    tpa_attempt_guard #(
        .LIMIT_W(3)
    ) u_guard (
        .clk_sys(clk_sys),
        .reset(reset),
        .verify(is_verify),
        .match(match),
        .limit(limit),
        .pass(pass),
        .locked(locked),
        .fail_count(fail_count)
    );

    // R1 R9 secrets take guarded writes regardless of the config lock.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            password <= tpa_pkg::PWD_RESET;
            ack_value <= tpa_pkg::ACK_RESET;
        end else if (is_write && write_ok) begin
            if (req.page == PWD_PAGE) begin
                password <= req.data;
            end
            if (req.page == ACK_PAGE) begin
                ack_value <= req.data[15:0];
            end
        end
    end

    // R17 session follows the last verification
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            auth <= 1'b0;
        end else if (is_verify) begin
            // R13 lock forces failure
            auth <= pass;
        end else if (req.valid && req.cmd == tpa_pkg::TPA_CMD_DEACTIVATE) begin
            auth <= 1'b0;
        end
    end

    // One reply per request, one cycle later; a refusal carries no data.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rsp <= '0;
        end else begin
            rsp.valid <= req.valid;
            rsp.grant <= 1'b0;
            rsp.data <= 32'h0000_0000;
            if (req.valid) begin
                case (req.cmd)
                    tpa_pkg::TPA_CMD_READ: begin
                        rsp.grant <= read_ok;
                        rsp.data <= read_ok ? masked : 32'h0000_0000;
                    end
                    tpa_pkg::TPA_CMD_WRITE, tpa_pkg::TPA_CMD_COMPAT_WRITE: begin
                        rsp.grant <= write_ok;
                    end
                    tpa_pkg::TPA_CMD_VERIFY: begin
                        // R17 acknowledge value on match
                        rsp.grant <= pass;
                        rsp.data <= pass ? {16'h0000, ack_value} : 32'h0000_0000;
                    end
                    tpa_pkg::TPA_CMD_DEACTIVATE: begin
                        rsp.grant <= 1'b1;
                    end
                    default: begin
                        rsp.grant <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Write address channel; ready returns only after the response is taken.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b1;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    // Write data channel, independent of address order.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b1;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    // Write response; unmapped addresses answer with a slave error.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tpa_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr == tpa_pkg::CONFIG_OFFSET || aw_addr == tpa_pkg::STATUS_OFFSET) begin
                s_axi_bresp <= tpa_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= tpa_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // R2 delivered configuration; the config lock freezes it until reset.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fpp <= tpa_pkg::FPP_RESET;
            limit <= tpa_pkg::LIMIT_RESET;
            scope <= tpa_pkg::SCOPE_RESET;
            cfg_lock <= tpa_pkg::CFG_LOCK_RESET;
        end else if (wr_fire && aw_addr == tpa_pkg::CONFIG_OFFSET && !cfg_lock) begin
            if (w_strb[0]) begin
                fpp <= w_data[tpa_pkg::FPP_LSB+:8];
            end
            if (w_strb[1]) begin
                limit <= w_data[tpa_pkg::LIMIT_LSB+:3];
                scope <= w_data[tpa_pkg::SCOPE_BIT];
                cfg_lock <= w_data[tpa_pkg::CFG_LOCK_BIT];
            end
        end
    end

    // Read channel; status shows session, lock and counter state.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= tpa_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= tpa_pkg::RESP_OKAY;
            case (s_axi_araddr)
                tpa_pkg::CONFIG_OFFSET: begin
                    s_axi_rdata <= {19'h0, cfg_lock, scope, limit, fpp};
                end
                tpa_pkg::STATUS_OFFSET: begin
                    s_axi_rdata <= {25'h0, cfg_guarded, protection_scope_bit_active, fail_count, locked, auth};
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= tpa_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_pwd_read_zero: assert property (req.valid && req.cmd == tpa_pkg::TPA_CMD_READ && req.page == PWD_PAGE // R6
        |=> rsp.valid && rsp.data == 32'h0000_0000)
        else $error("Password bytes leaked on a read.");
    a_ack_read_zero: assert property (req.valid && req.cmd == tpa_pkg::TPA_CMD_READ && req.page == ACK_PAGE // R6
        |=> rsp.data[15:0] == 16'h0000)
        else $error("Acknowledge bytes leaked on a read.");
    a_locked_verify_fail: assert property (is_verify && locked |=> !rsp.grant && !auth) // R13
        else $error("Verification passed while locked.");
    a_verify_ack_reply: assert property (is_verify && match && !locked // R17
        |=> rsp.grant && auth && rsp.data[15:0] == $past(ack_value))
        else $error("Good password did not return the acknowledge value.");
    a_open_write_ok: assert property (is_write && fpp == tpa_pkg::FPP_RESET && in_range |=> rsp.grant) // R3
        else $error("Write refused with protection off.");
    a_guard_write_deny: assert property (is_write && guarded && !auth |=> !rsp.grant) // R8
        else $error("Guarded write granted without verification.");
    a_scope_read_open: assert property (req.valid && req.cmd == tpa_pkg::TPA_CMD_READ && in_range && !scope // R15
        |=> rsp.grant)
        else $error("Read refused under write-only protection.");
    a_lock_bit_ignored: assert property (is_write && write_ok && req.page == PWD_PAGE && cfg_lock // R9
        |=> password == $past(req.data))
        else $error("Config lock blocked a password write.");
    a_reset_threshold: assert property ($fell(reset) |-> fpp == tpa_pkg::FPP_RESET && !protection_scope_bit_active) // R2
        else $error("Threshold not at its delivered value.");
    a_cfg_guard_map: assert property (fpp <= CFG_PAGE |-> cfg_guarded) // R16
        else $error("Configuration pages not guarded.");
    a_cfg_guard_high: assert property (fpp >= CFG_PAGE && fpp <= LAST_PAGE |-> cfg_guarded) // R16
        else $error("Threshold on a configuration page left them unguarded.");

    c_verify_pass: cover property (is_verify && match ##1 rsp.grant);
    c_lockout: cover property (is_verify && !match ##1 locked);
    c_hidden_read: cover property (req.valid && req.cmd == tpa_pkg::TPA_CMD_READ && req.page == PWD_PAGE && read_ok);
    c_deny_read: cover property (req.valid && req.cmd == tpa_pkg::TPA_CMD_READ && !read_ok && in_range);
endmodule : tpa_access_control
`default_nettype wire

//--- rtl/tpa_pkg.sv
// Shared constants, types and decode helpers of the tag password access control.
`default_nettype none
package tpa_pkg;
    // Register bus geometry and byte addresses.
    localparam int ADDR_W = 8;
    localparam logic [7:0] CONFIG_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    // Field positions inside the configuration word.
    localparam int FPP_LSB = 0;
    localparam int LIMIT_LSB = 8;
    localparam int SCOPE_BIT = 11;
    localparam int CFG_LOCK_BIT = 12;
    // Values after reset; the delivered state leaves protection off.
    localparam logic [7:0] FPP_RESET = 8'hFF;
    localparam logic [2:0] LIMIT_RESET = 3'h0;
    localparam logic SCOPE_RESET = 1'b0;
    localparam logic CFG_LOCK_RESET = 1'b0;
    localparam logic [31:0] PWD_RESET = 32'hFFFF_FFFF;
    localparam logic [15:0] ACK_RESET = 16'h0000;
    // Page map of the two memory sizes.
    localparam logic [7:0] SMALL_CFG_PAGE = 8'h29;
    localparam logic [7:0] LARGE_CFG_PAGE = 8'hE3;
    localparam logic [7:0] SMALL_PWD_PAGE = 8'h2B;
    localparam logic [7:0] LARGE_PWD_PAGE = 8'hE5;
    localparam logic [7:0] SMALL_ACK_PAGE = 8'h2C;
    localparam logic [7:0] LARGE_ACK_PAGE = 8'hE6;
    // Bus answers.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Commands handed over by the frame decoder.
    typedef enum logic [2:0] {
        TPA_CMD_READ,
        TPA_CMD_WRITE,
        TPA_CMD_COMPAT_WRITE,
        TPA_CMD_VERIFY,
        TPA_CMD_DEACTIVATE
    } tpa_cmd_t;

    typedef struct packed {
        logic valid;
        tpa_cmd_t cmd;
        logic [7:0] page;
        logic [31:0] data;
    } tpa_req_t;

    typedef struct packed {
        logic valid;
        logic grant;
        logic [31:0] data;
    } tpa_rsp_t;

    // A page is guarded when the threshold lies in memory and the page is at or above it.
    function automatic logic tpa_guarded(input logic [7:0] page, input logic [7:0] fpp,
                                         input logic [7:0] last_page);
        tpa_guarded = (fpp <= last_page) && (page >= fpp);
    endfunction : tpa_guarded
endpackage : tpa_pkg
`default_nettype wire

//--- rtl/tpa_attempt_guard.sv
// Failed verification counter and permanent lockout of the tag password access control.
`default_nettype none
module tpa_attempt_guard #(
    parameter int LIMIT_W = 3
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Verification event.
    input wire logic verify,
    input wire logic match,
    input wire logic [LIMIT_W-1:0] limit,
    // Outcome and state.
    output logic pass,
    output logic locked,
    output logic [LIMIT_W-1:0] fail_count
);
    // A locked guard refuses every password, right or wrong.
    assign pass = match && !locked;

    // Counter and lock advance only on a verification.
    // R11 zero limit disables counting.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fail_count <= '0;
            locked <= 1'b0;
        end else if (verify && !locked) begin
            if (match) begin
                // R14 success clears counter
                fail_count <= '0;
            end else if (limit != '0) begin
                // R12 count then lock
                if (fail_count >= limit) begin
                    locked <= 1'b1;
                end else begin
                    fail_count <= fail_count + 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_count_clear: assert property (verify && match && !locked |=> fail_count == '0) // R14
        else $error("Failed count not cleared by a good password.");
    a_lock_at_limit: assert property (verify && !match && !locked && limit != '0 && fail_count >= limit // R12
        |=> locked)
        else $error("Guard did not lock after the limit.");
    a_limit_off: assert property (verify && !locked && limit == '0 |=> !locked && $stable(fail_count)) // R11
        else $error("Counting happened with the limit switched off.");
    a_lock_sticks: assert property (locked |=> locked) // R12
        else $error("Permanent lock was released.");
endmodule : tpa_attempt_guard
`default_nettype wire

//--- dv/tpa_reader_model.sv
// Reader model that hands commands to the access control through the decoder port.
`default_nettype none
module tpa_reader_model (
    // Clock.
    input wire logic clk_sys,
    // Command out, answer back.
    output tpa_pkg::tpa_req_t req,
    input wire tpa_pkg::tpa_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;

    // The port is idle until the first command.
    initial req = '0;

    // Send one command and take the answer one edge after the edge that took it.
    task automatic issue(input tpa_pkg::tpa_cmd_t cmd, input logic [7:0] page, input logic [31:0] data,
                         output tpa_pkg::tpa_rsp_t got);
        @(posedge clk_sys);
        req <= '{valid: 1'b1, cmd: cmd, page: page, data: data};
        @(posedge clk_sys);
        // A released port drops valid and inverts page and data but keeps cmd, so a stale copy is never mistaken for a command.
        req <= '{valid: 1'b0, cmd: cmd, page: ~page, data: ~data};
        @(posedge clk_sys);
        got = rsp;
    endtask : issue
endmodule : tpa_reader_model
`default_nettype wire

//--- dv/tpa_access_control_tb.sv
// Self-checking testbench of the tag password access control.
`default_nettype none
module tpa_access_control_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam tpa_pkg::tpa_cmd_t RD = tpa_pkg::TPA_CMD_READ;
    localparam tpa_pkg::tpa_cmd_t WR = tpa_pkg::TPA_CMD_WRITE;
    localparam tpa_pkg::tpa_cmd_t CW = tpa_pkg::TPA_CMD_COMPAT_WRITE;
    localparam tpa_pkg::tpa_cmd_t VF = tpa_pkg::TPA_CMD_VERIFY;
    localparam logic [7:0] CFG = tpa_pkg::CONFIG_OFFSET;
    localparam logic [7:0] STS = tpa_pkg::STATUS_OFFSET;
    localparam logic [7:0] PWD_PG = tpa_pkg::SMALL_PWD_PAGE;
    localparam logic [1:0] OK = tpa_pkg::RESP_OKAY;
    localparam logic [31:0] SECRET_PASSWORD = 32'h4433_2211;

    logic clk_sys;
    logic reset = 1'b1;
    tpa_pkg::tpa_req_t req;
    tpa_pkg::tpa_rsp_t rsp;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp;
    int mismatches = 0;
    int compares = 0;

    tpa_access_control #(.LARGE_VARIANT(1'b0)) dut (
        .clk_sys(clk_sys), .reset(reset), .req(req), .rsp(rsp),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    tpa_reader_model rdr (.clk_sys(clk_sys), .req(req), .rsp(rsp));

    // Free-running 100 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // One comparison; case inequality so an unknown never passes.
    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // Register write; address and data offered together, each dropped when taken.
    task automatic axi_wr(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] exp);
        @(posedge clk_sys);
        awaddr <= addr;
        wdata <= data;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("write response", {32'h0, exp}, {32'h0, bresp});
    endtask : axi_wr

    // Register read; response code and data checked together.
    task automatic axi_rd(input logic [7:0] addr, input logic [33:0] exp);
        @(posedge clk_sys);
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("register read", exp, {rresp, rdata});
    endtask : axi_rd

    // One reader command with its expected answer.
    task automatic op(input tpa_pkg::tpa_cmd_t cmd, input logic [7:0] page, input logic [31:0] data,
                      input logic grant, input logic [31:0] exp);
        tpa_pkg::tpa_rsp_t r;
        rdr.issue(cmd, page, data, r);
        chk("command answer", {1'b1, grant, exp}, r);
    endtask : op

    // Field leaves the reader; the session ends.
    task automatic leave();
        tpa_pkg::tpa_rsp_t r;
        rdr.issue(tpa_pkg::TPA_CMD_DEACTIVATE, 8'h00, 32'h0, r);
        chk("deactivate answer", {1'b1, 1'b1, 32'h0}, r);
    endtask : leave

    // Print the verdict and stop.
    task automatic tally_and_finish();
        if (mismatches == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // Cut a hang short long after the sequence should have ended.
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        axi_rd(CFG, {OK, 32'h0000_00FF});
        axi_rd(STS, {OK, 32'h0});
        op(WR, PWD_PG, SECRET_PASSWORD, 1'b1, 32'h0);
        op(CW, tpa_pkg::SMALL_ACK_PAGE, 32'h0000_BEEF, 1'b1, 32'h0);
        op(RD, PWD_PG, 32'hA5A5_5A5A, 1'b1, 32'h0);
        repeat (2) op(VF, 8'h00, 32'h1122_3344, 1'b0, 32'h0);
        axi_rd(STS, {OK, 32'h0});
        op(VF, 8'h00, SECRET_PASSWORD, 1'b1, 32'h0000_BEEF);
        axi_wr(8'h08, 32'hFFFF_FFFF, tpa_pkg::RESP_SLVERR);
        axi_rd(8'h08, {tpa_pkg::RESP_SLVERR, 32'h0});
        axi_wr(STS, 32'hFFFF_FFFF, OK);
        // Threshold 10h, limit 2, writes guarded only.
        axi_wr(CFG, 32'h0000_0210, OK);
        leave();
        op(RD, 8'h0F, 32'h1111_1111, 1'b1, 32'h1111_1111);
        op(WR, 8'h10, 32'h0000_0001, 1'b0, 32'h0);
        op(RD, 8'h10, 32'h2222_2222, 1'b1, 32'h2222_2222);
        op(WR, PWD_PG, 32'h8877_6655, 1'b0, 32'h0);
        op(VF, 8'h00, SECRET_PASSWORD, 1'b1, 32'h0000_BEEF);
        op(WR, PWD_PG, 32'h8877_6655, 1'b1, 32'h0);
        op(RD, PWD_PG, 32'h8877_6655, 1'b1, 32'h0);
        axi_rd(STS, {OK, 32'h61});
        // Reads guarded too, then the configuration frozen.
        axi_wr(CFG, 32'h0000_1A10, OK);
        axi_wr(CFG, 32'h0000_00FF, OK);
        axi_rd(CFG, {OK, 32'h0000_1A10});
        op(WR, PWD_PG, SECRET_PASSWORD, 1'b1, 32'h0);
        leave();
        op(RD, 8'h10, 32'h2222_2222, 1'b0, 32'h0);
        op(VF, 8'h00, 32'h0, 1'b0, 32'h0);
        axi_rd(STS, {OK, 32'h64});
        op(VF, 8'h00, SECRET_PASSWORD, 1'b1, 32'h0000_BEEF);
        axi_rd(STS, {OK, 32'h61});
        leave();
        repeat (2) op(VF, 8'h00, 32'h0, 1'b0, 32'h0);
        axi_rd(STS, {OK, 32'h68});
        op(VF, 8'h00, 32'h0, 1'b0, 32'h0);
        op(VF, 8'h00, SECRET_PASSWORD, 1'b0, 32'h0);
        op(RD, 8'h10, 32'h2222_2222, 1'b0, 32'h0);
        op(WR, 8'h0F, 32'h0000_0003, 1'b1, 32'h0);
        axi_rd(STS, {OK, 32'h6A});
        // Second reset in mid-run, then the threshold put on the password page.
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        op(VF, 8'h00, 32'hFFFF_FFFF, 1'b1, 32'h0);
        axi_wr(CFG, {24'h0, PWD_PG}, OK);
        axi_rd(STS, {OK, 32'h61});
        leave();
        op(WR, 8'h20, 32'h0000_0004, 1'b1, 32'h0);
        op(WR, PWD_PG, 32'h0, 1'b0, 32'h0);
        op(WR, 8'h2D, 32'h0, 1'b0, 32'h0);
        tally_and_finish();
    end
endmodule : tpa_access_control_tb
`default_nettype wire
